// ---- hdl/hsce_pkg.sv ----
// Purpose: types of the holdover state and command error block
// Assumes: nothing beyond the constants header
// Notes:   imported by no one; use hsce_pkg::name
package hsce_pkg;

  // ****************************************************************
  // operating states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_POWERUP,
    ST_LOCKED,
    ST_HOLDING,
    ST_WAIT_RECOVER,
    ST_RECOVERING
  } hsce_op_state_t;

  // ****************************************************************
  // parser fault classes
  // ****************************************************************
  typedef enum logic [4:0] {
    FAULT_SYNTAX_GENERIC,
    FAULT_BAD_CHAR,
    FAULT_UNKNOWN_TYPE,
    FAULT_SEPARATOR,
    FAULT_DATA_TYPE,
    FAULT_EXTRA_PARAM,
    FAULT_MISSING_PARAM,
    FAULT_NAME_LEN,
    FAULT_UNDEF_HEADER,
    FAULT_NUM_GENERIC,
    FAULT_NUM_RADIX,
    FAULT_NUM_EXPONENT,
    FAULT_NUM_DIGITS,
    FAULT_NUM_NOT_ALLOWED,
    FAULT_SUFFIX_BAD,
    FAULT_SUFFIX_LEN,
    FAULT_SUFFIX_NOT_ALLOWED
  } hsce_fault_t;

endpackage

// ---- hdl/hsce_regs.svh ----
// Purpose: constants of the holdover state and command error block
// Assumes: error codes are carried as 16-bit two's complement
// Notes:   definitions only
`ifndef HSCE_REGS_SVH
`define HSCE_REGS_SVH

// ****************************************************************
// error codes
// ****************************************************************
`define HSCE_CODE_NO_ERROR     16'h0000
`define HSCE_CODE_CMD_GENERIC  16'hff9c
`define HSCE_CODE_BAD_CHAR     16'hff9b
`define HSCE_CODE_SYNTAX       16'hff9a
`define HSCE_CODE_SEPARATOR    16'hff99
`define HSCE_CODE_DATA_TYPE    16'hff98
`define HSCE_CODE_EXTRA_PARAM  16'hff94
`define HSCE_CODE_MISS_PARAM   16'hff93
`define HSCE_CODE_NAME_LONG    16'hff90
`define HSCE_CODE_UNDEF_HDR    16'hff8f
`define HSCE_CODE_NUM_GENERIC  16'hff88
`define HSCE_CODE_NUM_RADIX    16'hff87
`define HSCE_CODE_NUM_EXPONENT 16'hff85
`define HSCE_CODE_NUM_DIGITS   16'hff84
`define HSCE_CODE_NUM_NOT_OK   16'hff80
`define HSCE_CODE_SUFFIX_BAD   16'hff7d
`define HSCE_CODE_SUFFIX_LONG  16'hff7a
`define HSCE_CODE_SUFFIX_NOT   16'hff76

// ****************************************************************
// length limits
// ****************************************************************
`define HSCE_MAX_NAME_LEN      16'h000c
`define HSCE_MAX_SUFFIX_LEN    16'h000c
`define HSCE_MAX_MANTISSA      16'h00ff

`endif

// ---- hdl/hsce_top.sv ----
// Purpose: operating-state machine and parser error queue
// Assumes: all inputs come from logic on clk_i; commands are pulses
// Notes:   error queue drops new errors when full and flags it
//
// Overview of operation
// - holdover indicator lit in three holdover states
// - holding left only by recovery command
// - waiting moves to recovering when conditions met
// - recovering locks, or falls back on external loss
// - powerup stays until first lock, then locked, or force, then holding
// - locked indicator lit while locked
// - empty queue reads +0; clear empties queue but keeps a fault raised with it
// - unclassified syntax fault reports -100
// - bad character -101, unknown type -102
// - bad separator reports -103
// - wrong data element type reports -104
// - extra parameter -108, missing parameter -109
// - name over twelve characters reports -112
// - unmatched valid header reports -113
// - numeric faults -120..-129, default -120
// - invalid radix character reports -121
// - mantissa over 255 digits -124, exponent -123
// - numeric value not accepted reports -128
// - malformed or unsuitable suffix reports -131
// - suffix over twelve characters reports -134
// - suffix after numeric not permitting one -138
`timescale 1ns/1ns
`include "hsce_regs.svh"
`default_nettype none

module hsce_top #(
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 reset_i,
  // receiver conditions
  input  wire logic                 lock_ok_i,
  input  wire logic                 recover_ok_i,
  input  wire logic                 ext_fail_i,
  // host commands
  input  wire logic                 force_holdover_command_i,
  input  wire logic                 recovery_command_i,
  input  wire logic                 clear_status_i,
  // parser faults
  input  wire logic                 fault_valid_i,
  input  wire hsce_pkg::hsce_fault_t fault_kind_i,
  input  wire logic [15:0]          fault_count_i,
  // error queue read
  input  wire logic                 err_rd_i,
  output var  logic                 err_valid_o,
  output var  logic [15:0]          err_code_o,
  output var  logic                 overflow_o,
  // state and indicators
  output var  hsce_pkg::hsce_op_state_t state_o,
  output var  logic                 holdover_led_o,
  output var  logic                 locked_led_o
);

  // ****************************************************************
  // sizing
  // ****************************************************************
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2) begin : g_depth_check
    $error("hsce_top: DEPTH must be at least 2");
  end

  typedef struct packed {
    hsce_pkg::hsce_op_state_t state;
    logic                     holdover_led;
    logic                     locked_led;
    logic [DEPTH-1:0][15:0]   mem;
    logic [PW-1:0]            wr_ptr;
    logic [PW-1:0]            rd_ptr;
    logic [CW-1:0]            count;
    logic                     rd_valid;
    logic [15:0]              rd_code;
    logic                     overflow;
  } hsce_regs_t;

  hsce_regs_t s_reg;
  hsce_regs_t s_next;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  // returns {error present, code}
  function automatic logic [16:0] classify(
    input hsce_pkg::hsce_fault_t k,
    input logic [15:0]           n
  );
    classify = {1'b1, `HSCE_CODE_CMD_GENERIC};
    case (k)
      hsce_pkg::FAULT_BAD_CHAR: begin
        classify = {1'b1, `HSCE_CODE_BAD_CHAR};
      end
      hsce_pkg::FAULT_UNKNOWN_TYPE: begin
        classify = {1'b1, `HSCE_CODE_SYNTAX};
      end
      hsce_pkg::FAULT_SEPARATOR: begin
        classify = {1'b1, `HSCE_CODE_SEPARATOR};
      end
      hsce_pkg::FAULT_DATA_TYPE: begin
        classify = {1'b1, `HSCE_CODE_DATA_TYPE};
      end
      hsce_pkg::FAULT_EXTRA_PARAM: begin
        classify = {1'b1, `HSCE_CODE_EXTRA_PARAM};
      end
      hsce_pkg::FAULT_MISSING_PARAM: begin
        classify = {1'b1, `HSCE_CODE_MISS_PARAM};
      end
      hsce_pkg::FAULT_NAME_LEN: begin
        classify = {n > `HSCE_MAX_NAME_LEN, `HSCE_CODE_NAME_LONG};
      end
      hsce_pkg::FAULT_UNDEF_HEADER: begin
        classify = {1'b1, `HSCE_CODE_UNDEF_HDR};
      end
      hsce_pkg::FAULT_NUM_GENERIC: begin
        classify = {1'b1, `HSCE_CODE_NUM_GENERIC};
      end
      hsce_pkg::FAULT_NUM_RADIX: begin
        classify = {1'b1, `HSCE_CODE_NUM_RADIX};
      end
      hsce_pkg::FAULT_NUM_EXPONENT: begin
        classify = {1'b1, `HSCE_CODE_NUM_EXPONENT};
      end
      hsce_pkg::FAULT_NUM_DIGITS: begin
        // caller strips leading zeros before counting
        classify = {n > `HSCE_MAX_MANTISSA, `HSCE_CODE_NUM_DIGITS};
      end
      hsce_pkg::FAULT_NUM_NOT_ALLOWED: begin
        classify = {1'b1, `HSCE_CODE_NUM_NOT_OK};
      end
      hsce_pkg::FAULT_SUFFIX_BAD: begin
        classify = {1'b1, `HSCE_CODE_SUFFIX_BAD};
      end
      hsce_pkg::FAULT_SUFFIX_LEN: begin
        classify = {n > `HSCE_MAX_SUFFIX_LEN, `HSCE_CODE_SUFFIX_LONG};
      end
      hsce_pkg::FAULT_SUFFIX_NOT_ALLOWED: begin
        classify = {1'b1, `HSCE_CODE_SUFFIX_NOT};
      end
      default: begin
        classify = {1'b1, `HSCE_CODE_CMD_GENERIC};
      end
    endcase
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  logic [16:0] cls;
  logic        push;
  logic        pop;
  logic        room;
  logic        push_ok;

  always_comb begin
    s_next = s_reg;
    cls = classify(fault_kind_i, fault_count_i);
    push = fault_valid_i && cls[16];
    pop = err_rd_i && (s_reg.count != '0) && !clear_status_i;
    room = (s_reg.count != CW'(DEPTH)) || pop;
    push_ok = push && room;
    s_next.rd_valid = 1'b0;
    case (s_reg.state)
      hsce_pkg::ST_POWERUP: begin
        if (force_holdover_command_i) begin
          s_next.state = hsce_pkg::ST_HOLDING;
        end else if (lock_ok_i) begin
          s_next.state = hsce_pkg::ST_LOCKED;
        end
      end
      hsce_pkg::ST_LOCKED: begin
        if (force_holdover_command_i) begin
          s_next.state = hsce_pkg::ST_HOLDING;
        end else if (ext_fail_i) begin
          s_next.state = hsce_pkg::ST_WAIT_RECOVER;
        end
      end
      hsce_pkg::ST_HOLDING: begin
        // no condition input can leave this state
        if (recovery_command_i) begin
          s_next.state = hsce_pkg::ST_WAIT_RECOVER;
        end
      end
      hsce_pkg::ST_WAIT_RECOVER: begin
        if (recover_ok_i) begin
          s_next.state = hsce_pkg::ST_RECOVERING;
        end
      end
      hsce_pkg::ST_RECOVERING: begin
        // loss beats lock: a lock seen with lost tracking is not trusted
        if (force_holdover_command_i) begin
          s_next.state = hsce_pkg::ST_HOLDING;
        end else if (ext_fail_i) begin
          s_next.state = hsce_pkg::ST_WAIT_RECOVER;
        end else if (lock_ok_i) begin
          s_next.state = hsce_pkg::ST_LOCKED;
        end
      end
      default: begin
        s_next.state = hsce_pkg::ST_POWERUP;
      end
    endcase
    s_next.holdover_led = (s_next.state == hsce_pkg::ST_HOLDING) ||
                          (s_next.state == hsce_pkg::ST_WAIT_RECOVER) ||
                          (s_next.state == hsce_pkg::ST_RECOVERING);
    s_next.locked_led = (s_next.state == hsce_pkg::ST_LOCKED);
    if (err_rd_i) begin
      s_next.rd_valid = 1'b1;
      s_next.rd_code = pop ? s_reg.mem[s_reg.rd_ptr]
                           : `HSCE_CODE_NO_ERROR;
    end
    if (clear_status_i) begin
      // an error raised in the clearing cycle survives the clear
      s_next.count = '0;
      s_next.rd_ptr = '0;
      s_next.wr_ptr = '0;
      s_next.overflow = 1'b0;
      if (push) begin
        s_next.mem[0] = cls[15:0];
        s_next.wr_ptr = PW'(1);
        s_next.count = CW'(1);
      end
    end else begin
      if (pop) begin
        s_next.rd_ptr = ptr_inc(s_reg.rd_ptr);
      end
      if (push_ok) begin
        s_next.mem[s_reg.wr_ptr] = cls[15:0];
        s_next.wr_ptr = ptr_inc(s_reg.wr_ptr);
      end
      if (push && !room) begin
        s_next.overflow = 1'b1;
      end
      s_next.count = CW'(s_reg.count + CW'(push_ok) - CW'(pop));
    end
  end
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign state_o        = s_reg.state;
  assign holdover_led_o = s_reg.holdover_led;
  assign locked_led_o   = s_reg.locked_led;
  assign err_valid_o    = s_reg.rd_valid;
  assign err_code_o     = s_reg.rd_code;
  assign overflow_o     = s_reg.overflow;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  logic first_push;
  assign first_push = fault_valid_i && (s_reg.count == '0) &&
                      !clear_status_i;
  a_holdover_led_states: assert property (
    holdover_led_o == ((state_o == hsce_pkg::ST_HOLDING) ||
      (state_o == hsce_pkg::ST_WAIT_RECOVER) ||
      (state_o == hsce_pkg::ST_RECOVERING)))
    else $error("holdover indicator disagrees with state");
  a_holding_stays: assert property (
    state_o == hsce_pkg::ST_HOLDING && !recovery_command_i
    |=> state_o == hsce_pkg::ST_HOLDING)
    else $error("holding left without recovery command");
  a_wait_to_recover: assert property (
    state_o == hsce_pkg::ST_WAIT_RECOVER && recover_ok_i
    |=> state_o == hsce_pkg::ST_RECOVERING && holdover_led_o)
    else $error("waiting did not start recovery");
  a_recover_outcome: assert property (
    state_o == hsce_pkg::ST_RECOVERING && !force_holdover_command_i
    |=> state_o == ($past(ext_fail_i) ? hsce_pkg::ST_WAIT_RECOVER :
        $past(lock_ok_i) ? hsce_pkg::ST_LOCKED : hsce_pkg::ST_RECOVERING))
    else $error("recovering went the wrong way");
  a_powerup_lock: assert property (
    state_o == hsce_pkg::ST_POWERUP && !force_holdover_command_i
    |=> state_o == ($past(lock_ok_i) ? hsce_pkg::ST_LOCKED
                                     : hsce_pkg::ST_POWERUP))
    else $error("powerup exit wrong");
  a_locked_led: assert property (
    locked_led_o == (state_o == hsce_pkg::ST_LOCKED))
    else $error("locked indicator disagrees with state");
  a_force_hold: assert property (
    force_holdover_command_i && state_o != hsce_pkg::ST_WAIT_RECOVER
    |=> state_o == hsce_pkg::ST_HOLDING)
    else $error("force holdover not obeyed");
  a_empty_read: assert property (
    err_rd_i && (s_reg.count == '0 || clear_status_i)
    |=> err_valid_o && err_code_o == `HSCE_CODE_NO_ERROR)
    else $error("empty queue read not +0");
  a_clear_empty: assert property (
    clear_status_i && !fault_valid_i |=> s_reg.count == '0)
    else $error("clear did not empty queue");
  a_generic_code: assert property (
    first_push && fault_kind_i == hsce_pkg::FAULT_SYNTAX_GENERIC
    |=> s_reg.count == CW'(1) &&
        s_reg.mem[s_reg.rd_ptr] == `HSCE_CODE_CMD_GENERIC)
    else $error("generic fault not -100");
  a_name_long: assert property (
    first_push && fault_kind_i == hsce_pkg::FAULT_NAME_LEN
    |=> s_reg.count == ($past(fault_count_i) > 16'h000c ? CW'(1) : CW'(0)))
    else $error("name length threshold wrong");
  a_mantissa_code: assert property (
    first_push && fault_kind_i == hsce_pkg::FAULT_NUM_DIGITS &&
    fault_count_i == 16'h0100
    |=> s_reg.mem[s_reg.rd_ptr] == `HSCE_CODE_NUM_DIGITS)
    else $error("mantissa fault not -124");
  a_queue_order: assert property (
    err_rd_i && !clear_status_i && s_reg.count != '0
    |=> err_valid_o && err_code_o == $past(s_reg.mem[s_reg.rd_ptr]) ##1
        !err_valid_o || $past(err_rd_i))
    else $error("read did not return oldest entry");
  c_recover_lock: cover property (
    state_o == hsce_pkg::ST_RECOVERING ##1 state_o == hsce_pkg::ST_LOCKED);
  c_force_locked: cover property (
    state_o == hsce_pkg::ST_LOCKED ##1 state_o == hsce_pkg::ST_HOLDING);
  c_overflow: cover property (overflow_o);
  c_read_entry: cover property (err_valid_o && err_code_o != 16'h0000);

endmodule

`default_nettype wire

// ---- verification/hsce_host_model.sv ----
// Purpose: host controller model issuing commands and error reads
// Assumes: one-cycle pulses, driven 1 ns after the rising edge
// Notes:   tasks start and end 1 ns after a rising edge
`timescale 1ns/1ns
`default_nettype none

module hsce_host_model (
  // clock
  input  wire logic        clk_i,
  // host commands
  output var  logic        force_holdover_command_o,
  output var  logic        recovery_command_o,
  output var  logic        clear_status_o,
  // error queue read
  output var  logic        err_rd_o,
  input  wire logic        err_valid_i,
  input  wire logic [15:0] err_code_i
);

  initial begin
    force_holdover_command_o = 1'b0;
    recovery_command_o       = 1'b0;
    clear_status_o           = 1'b0;
    err_rd_o                 = 1'b0;
  end

  task automatic send_force();
    force_holdover_command_o = 1'b1;
    @(posedge clk_i);
    #1 force_holdover_command_o = 1'b0;
  endtask

  // only way out of holding
  task automatic send_recovery();
    recovery_command_o = 1'b1;
    @(posedge clk_i);
    #1 recovery_command_o = 1'b0;
  endtask

  task automatic send_clear();
    clear_status_o = 1'b1;
    @(posedge clk_i);
    #1 clear_status_o = 1'b0;
  endtask

  // answer stands only in the cycle after the request edge
  // idle edge after it, so a second read never re-raises in one step
  task automatic read_err(output logic v, output logic [15:0] c);
    err_rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    v = err_valid_i;
    c = err_code_i;
    err_rd_o = 1'b0;
    @(posedge clk_i);
    #1;
  endtask

endmodule

`default_nettype wire

// ---- verification/tb_top.sv ----
// Purpose: self-checking bench of the holdover state and error queue
// Assumes: inputs change 1 ns after the rising edge
// Notes:   depth cut to 4 so that overflow comes quickly
`timescale 1ns/1ns
`include "hsce_regs.svh"
`default_nettype none

module tb_top;
  localparam int DEPTH = 4;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic                     clk_i = 1'b0;
  logic                     reset_i;
  logic                     lock_ok, recover_ok, ext_fail;
  logic                     force_holdover_command, recovery_command;
  logic                     clear_status, err_rd, err_valid, overflow;
  logic                     fault_valid, hold_led, lock_led;
  hsce_pkg::hsce_fault_t    fault_kind;
  logic [15:0]              fault_count, err_code;
  hsce_pkg::hsce_op_state_t state;
  int                       miscompares = 0;
  int                       n_tests = 0;
  int                       cycles = 0;
  logic [15:0]              code_tab [17] = '{
    `HSCE_CODE_CMD_GENERIC, `HSCE_CODE_BAD_CHAR, `HSCE_CODE_SYNTAX,
    `HSCE_CODE_SEPARATOR, `HSCE_CODE_DATA_TYPE, `HSCE_CODE_EXTRA_PARAM,
    `HSCE_CODE_MISS_PARAM, `HSCE_CODE_NAME_LONG, `HSCE_CODE_UNDEF_HDR,
    `HSCE_CODE_NUM_GENERIC, `HSCE_CODE_NUM_RADIX, `HSCE_CODE_NUM_EXPONENT,
    `HSCE_CODE_NUM_DIGITS, `HSCE_CODE_NUM_NOT_OK, `HSCE_CODE_SUFFIX_BAD,
    `HSCE_CODE_SUFFIX_LONG, `HSCE_CODE_SUFFIX_NOT};

  always #2 clk_i = ~clk_i;

  hsce_top #(.DEPTH(DEPTH)) i_dut (
    .clk_i(clk_i), .reset_i(reset_i), .lock_ok_i(lock_ok),
    .recover_ok_i(recover_ok), .ext_fail_i(ext_fail),
    .force_holdover_command_i(force_holdover_command),
    .recovery_command_i(recovery_command), .clear_status_i(clear_status),
    .fault_valid_i(fault_valid), .fault_kind_i(fault_kind),
    .fault_count_i(fault_count), .err_rd_i(err_rd),
    .err_valid_o(err_valid), .err_code_o(err_code),
    .overflow_o(overflow), .state_o(state), .holdover_led_o(hold_led),
    .locked_led_o(lock_led));

  hsce_host_model i_host (
    .clk_i(clk_i), .force_holdover_command_o(force_holdover_command),
    .recovery_command_o(recovery_command), .clear_status_o(clear_status),
    .err_rd_o(err_rd), .err_valid_i(err_valid), .err_code_i(err_code));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // hang guard, well above the roughly 170 cycles needed
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic check_eq(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step();
    @(posedge clk_i);
    #1;
  endtask

  task automatic check_st(input hsce_pkg::hsce_op_state_t st);
    logic h;
    h = (st == hsce_pkg::ST_HOLDING) || (st == hsce_pkg::ST_RECOVERING);
    h = h || (st == hsce_pkg::ST_WAIT_RECOVER);
    check_eq(16'(state), 16'(st));
    check_eq(16'(hold_led), 16'(h));
    check_eq(16'(lock_led), 16'(st == hsce_pkg::ST_LOCKED));
  endtask

  task automatic push(input hsce_pkg::hsce_fault_t k, input logic [15:0] n);
    fault_valid = 1'b1;
    fault_kind  = k;
    fault_count = n;
    step();
    fault_valid = 1'b0;
    // idle edge so back-to-back pushes never re-raise in one step
    step();
  endtask

  task automatic expect_read(input logic [15:0] exp);
    logic        v;
    logic [15:0] c;
    i_host.read_err(v, c);
    check_eq(16'(v), 16'h0001);
    check_eq(c, exp);
  endtask

  task automatic do_reset();
    reset_i = 1'b1;
    step();
    reset_i = 1'b0;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic test_states();
    check_st(hsce_pkg::ST_POWERUP);
    expect_read(`HSCE_CODE_NO_ERROR);
    recover_ok = 1'b1;
    repeat (3) step();
    check_st(hsce_pkg::ST_POWERUP);
    lock_ok = 1'b1;
    step();
    check_st(hsce_pkg::ST_LOCKED);
    i_host.send_recovery();
    check_st(hsce_pkg::ST_LOCKED);
    i_host.send_force();
    check_st(hsce_pkg::ST_HOLDING);
    repeat (3) step();
    check_st(hsce_pkg::ST_HOLDING);
    lock_ok = 1'b0;
    recover_ok = 1'b0;
    i_host.send_recovery();
    check_st(hsce_pkg::ST_WAIT_RECOVER);
    i_host.send_force();
    check_st(hsce_pkg::ST_WAIT_RECOVER);
    recover_ok = 1'b1;
    step();
    check_st(hsce_pkg::ST_RECOVERING);
    ext_fail = 1'b1;
    step();
    check_st(hsce_pkg::ST_WAIT_RECOVER);
    ext_fail = 1'b0;
    step();
    check_st(hsce_pkg::ST_RECOVERING);
    i_host.send_force();
    check_st(hsce_pkg::ST_HOLDING);
    i_host.send_recovery();
    step();
    lock_ok = 1'b1;
    step();
    check_st(hsce_pkg::ST_LOCKED);
    ext_fail = 1'b1;
    step();
    check_st(hsce_pkg::ST_WAIT_RECOVER);
    ext_fail = 1'b0;
    $display("test states done");
  endtask

  task automatic test_powerup();
    lock_ok = 1'b0;
    push(hsce_pkg::FAULT_BAD_CHAR, 16'h0000);
    do_reset();
    i_host.send_force();
    check_st(hsce_pkg::ST_HOLDING);
    expect_read(`HSCE_CODE_NO_ERROR);
    $display("test powerup done");
  endtask

  task automatic test_codes();
    hsce_pkg::hsce_fault_t k;
    logic [15:0]           n;
    for (int i = 0; i < 17; i++) begin
      k = hsce_pkg::hsce_fault_t'(i[4:0]);
      n = 16'h0000;
      if (k == hsce_pkg::FAULT_NAME_LEN) n = `HSCE_MAX_NAME_LEN + 16'h0001;
      if (k == hsce_pkg::FAULT_SUFFIX_LEN) n = `HSCE_MAX_SUFFIX_LEN + 16'h0001;
      if (k == hsce_pkg::FAULT_NUM_DIGITS) n = `HSCE_MAX_MANTISSA + 16'h0001;
      push(k, n);
      if (i < 9) expect_read(code_tab[i]);
      else expect_read(code_tab[i]);
    end
    push(hsce_pkg::hsce_fault_t'(5'h1f), 16'h0000);
    expect_read(`HSCE_CODE_CMD_GENERIC);
    push(hsce_pkg::FAULT_NAME_LEN, `HSCE_MAX_NAME_LEN);
    push(hsce_pkg::FAULT_NUM_DIGITS, `HSCE_MAX_MANTISSA);
    push(hsce_pkg::FAULT_SUFFIX_LEN, `HSCE_MAX_SUFFIX_LEN);
    expect_read(`HSCE_CODE_NO_ERROR);
    $display("test codes done");
  endtask

  task automatic test_queue();
    push(hsce_pkg::FAULT_BAD_CHAR, 16'h0000);
    push(hsce_pkg::FAULT_SEPARATOR, 16'h0000);
    push(hsce_pkg::FAULT_SUFFIX_BAD, 16'h0000);
    expect_read(`HSCE_CODE_BAD_CHAR);
    expect_read(`HSCE_CODE_SEPARATOR);
    expect_read(`HSCE_CODE_SUFFIX_BAD);
    expect_read(`HSCE_CODE_NO_ERROR);
    for (int i = 0; i < DEPTH; i++) push(hsce_pkg::FAULT_MISSING_PARAM, 16'h0);
    push(hsce_pkg::FAULT_EXTRA_PARAM, 16'h0000);
    check_eq(16'(overflow), 16'h0001);
    for (int i = 0; i < DEPTH; i++) expect_read(`HSCE_CODE_MISS_PARAM);
    expect_read(`HSCE_CODE_NO_ERROR);
    push(hsce_pkg::FAULT_DATA_TYPE, 16'h0000);
    i_host.send_clear();
    check_eq(16'(overflow), 16'h0000);
    expect_read(`HSCE_CODE_NO_ERROR);
    // clear and fault in one cycle: the new fault survives
    push(hsce_pkg::FAULT_BAD_CHAR, 16'h0000);
    fork
      i_host.send_clear();
      push(hsce_pkg::FAULT_SEPARATOR, 16'h0000);
    join
    expect_read(`HSCE_CODE_SEPARATOR);
    // clear and read in one cycle: the read sees +0
    push(hsce_pkg::FAULT_BAD_CHAR, 16'h0000);
    fork
      i_host.send_clear();
      expect_read(`HSCE_CODE_NO_ERROR);
    join
    expect_read(`HSCE_CODE_NO_ERROR);
    $display("test queue done");
  endtask

  initial begin
    reset_i = 1'b1;
    lock_ok = 1'b0;
    recover_ok = 1'b0;
    ext_fail = 1'b0;
    fault_valid = 1'b0;
    fault_kind = hsce_pkg::FAULT_SYNTAX_GENERIC;
    fault_count = 16'h0000;
    repeat (10) @(posedge clk_i);
    #1 reset_i = 1'b0;
    test_states();
    test_powerup();
    test_codes();
    test_queue();
    final_report();
  end

endmodule

`default_nettype wire
